// file: design/serial_bit_memory_access.v
`timescale 1ns/1ps
`default_nettype none
`include "bit_access_defines.vh"
// card-side bit-serial access front end with an apb register view
module serial_bit_memory_access #(
  parameter ADDR_W   = `ADDR_W,
  parameter MEM_BITS = `MEM_BITS
) (
  // apb clock and power-on reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // card pins from the reader
  input  wire        card_clk,
  input  wire        card_rst,
  input  wire        program_select_input,
  // open-drain data line
  input  wire        data_in,
  output wire        data_out,
  output wire        data_oe,
  // bit trace stream: {addr, bit}
  output wire        trace_valid,
  input  wire        trace_ready,
  output wire [11:0] trace_data
);
  // synchronised pins
  wire clk_s;
  wire rst_s;
  wire prog_sel_s;
  wire dat_s;
  pin_sync u_sync_clk (.pclk(pclk), .presetn(presetn), .d(card_clk), .q(clk_s));
  pin_sync u_sync_rst (.pclk(pclk), .presetn(presetn), .d(card_rst), .q(rst_s));
  pin_sync u_sync_prog_sel (.pclk(pclk), .presetn(presetn), .d(program_select_input), .q(prog_sel_s));
  pin_sync u_sync_dat (.pclk(pclk), .presetn(presetn), .d(data_in), .q(dat_s));

  // edge history, taken from the synchronised copies only
  reg clk_prev_q;
  reg rst_prev_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev_q <= 1'b0;
      rst_prev_q <= 1'b0; // matches the sync reset level, so no false fall
    end else begin
      clk_prev_q <= clk_s;
      rst_prev_q <= rst_s;
    end
  end
  wire clk_fall = clk_prev_q && !clk_s;
  wire rst_fall = rst_prev_q && !rst_s;

  // control registers
  reg              enable_q;
  reg [ADDR_W-1:0] rd_limit_q;
  reg [ADDR_W-1:0] mem_addr_q;
  reg              refused_q;
  reg [15:0]       pulse_cnt_q;

  // memory array, flip-flops addressed by index
  reg mem_q [0:MEM_BITS-1];

  // flags: clear-on-reset group and retained group
  reg cleared_on_reset_flag_1;
  reg cleared_on_reset_flag_2;
  reg cleared_on_reset_flag_3;
  reg retained_flag_a;
  reg retained_p_flag_first;
  reg retained_p_flag_second;
  reg retained_p_flag_third;
  reg retained_r_flag_first;
  reg retained_r_flag_second;
  reg retained_r_flag_third;

  // bit address counter, eleven bits covers 0..1599
  reg  [ADDR_W-1:0] addr_q; // RL15
  reg  [ADDR_W-1:0] addr_d;
  reg               addr_zero_evt;
  wire              buf_in_ready;

  // the counter stalls when the trace buffer is full, so no bit is lost
  wire              step_ok = enable_q && buf_in_ready;

  // next address: reset edge wins over a clock edge in the same cycle
  always @* begin
    addr_d        = addr_q;
    addr_zero_evt = 1'b0;
    if (rst_fall && !clk_s) begin
      addr_d        = {ADDR_W{1'b0}}; // RL1
      addr_zero_evt = 1'b1;
    end else if (clk_fall && !rst_s && step_ok) begin // RL7
      if (addr_q == `ADDR_LAST) begin
        addr_d        = {ADDR_W{1'b0}}; // RL8
        addr_zero_evt = 1'b1;
      end else begin
        addr_d = addr_q + {{(ADDR_W-1){1'b0}}, 1'b1}; // RL6
      end
    end
  end

  // address register and pulse counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q      <= {ADDR_W{1'b0}}; // RL5
      pulse_cnt_q <= 16'h0000;
    end else begin
      addr_q <= addr_d;
      if (addr_zero_evt && rst_fall)
        pulse_cnt_q <= 16'h0000;
      else if (addr_d != addr_q)
        pulse_cnt_q <= pulse_cnt_q + 16'h0001;
    end
  end

  // access decision by address; only reads are modelled here
  wire in_issuer  = (addr_q >= `ISSUER_ZONE_LO); // RL10
  wire rd_allowed = (addr_q <= rd_limit_q); // RL11
  wire rd_request = !rst_s && !prog_sel_s;
  // drive decision follows the address the flop is about to hold
  wire rd_allowed_d = (addr_d <= rd_limit_q); // RL11

  // open drain drive: only a zero at a permitted address pulls the line, on a read or while the reset pin is high
  reg drive_low_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_low_q <= 1'b0;
    end else begin
      drive_low_q <= enable_q && rd_allowed_d && (rd_request || rst_s) && !mem_q[addr_d]; // RL2 RL13
    end
  end
  assign data_out = 1'b0; // RL14
  assign data_oe  = drive_low_q; // RL14

  // refused read: a read attempt outside the permitted range
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      refused_q <= 1'b0;
    else if (clk_fall && rd_request && !rd_allowed)
      refused_q <= 1'b1; // RL11
    else if (psel && penable && pwrite && paddr == `OFS_STATUS && pwdata[0])
      refused_q <= 1'b0;
  end

  // apb decode
  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && !pwrite;
  wire mapped = (paddr == `OFS_CTRL) || (paddr == `OFS_STATUS) || (paddr == `OFS_ADDR) ||
                (paddr == `OFS_FLAGS) || (paddr == `OFS_MEM_ADDR) || (paddr == `OFS_MEM_DATA) ||
                (paddr == `OFS_RD_LIMIT);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // software-written control
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q   <= 1'b1;
      rd_limit_q <= `RD_LIMIT_RESET;
      mem_addr_q <= {ADDR_W{1'b0}};
    end else if (wr_en) begin
      case (paddr)
        `OFS_CTRL:     enable_q   <= pwdata[`CTRL_EN_BIT];
        `OFS_RD_LIMIT: rd_limit_q <= pwdata[ADDR_W-1:0];
        `OFS_MEM_ADDR: mem_addr_q <= pwdata[ADDR_W-1:0];
        default:       enable_q   <= enable_q;
      endcase
    end
  end

  // memory contents loaded by software, one bit per write
  integer i;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < MEM_BITS; i = i + 1)
        mem_q[i] <= 1'b1;
    end else if (wr_en && paddr == `OFS_MEM_DATA && mem_addr_q < MEM_BITS) begin
      mem_q[mem_addr_q] <= pwdata[0];
    end
  end

  // flags: software may set them, address reset clears only the first group
  wire flag_wr = wr_en && (paddr == `OFS_FLAGS);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cleared_on_reset_flag_1 <= 1'b0; // RL5
      cleared_on_reset_flag_2 <= 1'b0;
      cleared_on_reset_flag_3 <= 1'b0;
      retained_flag_a         <= 1'b0;
      retained_p_flag_first   <= 1'b0;
      retained_p_flag_second  <= 1'b0;
      retained_p_flag_third   <= 1'b0;
      retained_r_flag_first   <= 1'b0;
      retained_r_flag_second  <= 1'b0;
      retained_r_flag_third   <= 1'b0;
    end else begin
      if (flag_wr) begin
        // set beats clear: a write in the zeroing cycle still lands
        cleared_on_reset_flag_1 <= pwdata[0];
        cleared_on_reset_flag_2 <= pwdata[1];
        cleared_on_reset_flag_3 <= pwdata[2];
      end else if (addr_zero_evt) begin
        cleared_on_reset_flag_1 <= 1'b0; // RL3
        cleared_on_reset_flag_2 <= 1'b0;
        cleared_on_reset_flag_3 <= 1'b0;
      end
      // retained group ignores address reset
      if (flag_wr) begin // RL4
        retained_flag_a        <= pwdata[3];
        retained_p_flag_first  <= pwdata[4];
        retained_p_flag_second <= pwdata[5];
        retained_p_flag_third  <= pwdata[6];
        retained_r_flag_first  <= pwdata[7];
        retained_r_flag_second <= pwdata[8];
        retained_r_flag_third  <= pwdata[9];
      end
    end
  end

  wire [9:0] flags_vec = {retained_r_flag_third, retained_r_flag_second, retained_r_flag_first,
                          retained_p_flag_third, retained_p_flag_second, retained_p_flag_first,
                          retained_flag_a, cleared_on_reset_flag_3, cleared_on_reset_flag_2,
                          cleared_on_reset_flag_1};

  // read mux, registered for the data output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      case (paddr)
        `OFS_CTRL:     prdata <= {31'h00000000, enable_q};
        `OFS_STATUS:   prdata <= {16'h0000, pulse_cnt_q[11:0], in_issuer, prog_sel_s, dat_s, refused_q};
        `OFS_ADDR:     prdata <= {{(32-ADDR_W){1'b0}}, addr_q};
        `OFS_FLAGS:    prdata <= {22'h000000, flags_vec};
        `OFS_MEM_ADDR: prdata <= {{(32-ADDR_W){1'b0}}, mem_addr_q};
        `OFS_MEM_DATA: prdata <= {31'h00000000, mem_q[mem_addr_q]};
        `OFS_RD_LIMIT: prdata <= {{(32-ADDR_W){1'b0}}, rd_limit_q};
        default:       prdata <= 32'h00000000;
      endcase
    end
  end

  // trace of every bit presented on a clock step
  wire        trace_push = clk_fall && !rst_s && step_ok;
  wire [11:0] trace_word = {addr_d, mem_q[addr_d]};
  skid_buf2 #(.W(12)) u_trace (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (trace_push),
    .in_ready  (buf_in_ready),
    .in_data   (trace_word),
    .out_valid (trace_valid),
    .out_ready (trace_ready),
    .out_data  (trace_data)
  );
endmodule // serial_bit_memory_access
`default_nettype wire

// file: design/bit_access_defines.vh
// Behaviour
// [RL1] a falling reset pin edge while the card clock pin is low clears the bit address to zero.
// [RL2] right after an address reset the bit at address zero is shown on the data line.
// [RL3] each return of the address to zero clears the three clear-on-reset flags; the code lets a flags write in the same cycle win instead.
// [RL4] an address reset leaves the retained flags alone; only power-on reset clears them.
// [RL5] power-on reset clears every flag and sets the address to zero.
// [RL6] each falling edge of the card clock pin advances the address by one; the code holds the address instead while the trace buffer is full.
// [RL7] the address advances only while the reset pin is low.
// [RL8] from address 1599 the next clock pulse returns the address to zero.
// [RL9] the host reaches an address by an address reset and that many clock pulses.
// [RL10] the issuer zone starts at bit address 16, reached after reset and 16 pulses.
// [RL11] the device decides from the address which operations are allowed and refuses the rest.
// [RL12] for a read the host keeps the reset pin and program select low.
// [RL13] when a read is allowed the addressed memory bit is driven onto the data line.
// [RL14] the data line is open drain: zero pulls low, one releases it.
// [RL15] the bit address counter is at least eleven bits wide.
`ifndef BIT_ACCESS_DEFINES_VH
`define BIT_ACCESS_DEFINES_VH
`define ADDR_W          11
`define ADDR_LAST       11'h63f
`define ISSUER_ZONE_LO  11'h010
`define MEM_BITS        1600
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_ADDR        12'h008
`define OFS_FLAGS       12'h00c
`define OFS_MEM_ADDR    12'h010
`define OFS_MEM_DATA    12'h014
`define OFS_RD_LIMIT    12'h018
`define CTRL_RESET      32'h00000001
`define RD_LIMIT_RESET  11'h63f
`define CTRL_EN_BIT     0
`define CTRL_SET_FLAG_BIT 1
`endif

// file: design/pin_sync.v
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for one pin
module pin_sync (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // pin and result
  input  wire d,
  output wire q
);
  reg meta_q;
  reg sync_q;
  // second flop is the only reader of the first
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end
  assign q = sync_q;
endmodule // pin_sync
`default_nettype wire

// file: design/skid_buf2.v
`timescale 1ns/1ps
`default_nettype none
// two-entry buffer, valid/ready on both sides
module skid_buf2 #(
  parameter W = 12
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // fill side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // drain side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_q [0:1];
  reg         wp_q;
  reg         rp_q;
  reg [1:0]   cnt_q;
  wire        push = in_valid && in_ready;
  wire        pop  = out_valid && out_ready;
  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
  // pointers and occupancy
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= {W{1'b0}};
      mem_q[1] <= {W{1'b0}};
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q        <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule // skid_buf2
`default_nettype wire

// file: dv/bit_access_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "bit_access_defines.vh"
// port-level watch on apb, card pins and trace stream
module bit_access_checker #(
  parameter ADDR_W   = 11,
  parameter MEM_BITS = 1600
) (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  // card pins
  input wire        card_rst,
  input wire        program_select_input,
  input wire        data_out,
  input wire        data_oe,
  // trace stream
  input wire        trace_valid,
  input wire        trace_ready,
  input wire [11:0] trace_data
);
  // reset pin parked high long enough for the sync to settle
  sequence rst_quiet;
    (card_rst && !trace_valid) [*8];
  endsequence
  // receiver holding off a waiting word
  sequence stalled;
    trace_valid && !trace_ready;
  endsequence
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  open_drain_a: assert property (data_oe |-> !data_out)
    else $error("data line driven high");
  rst_quiet_a: assert property (rst_quiet |=> !trace_valid)
    else $error("step taken with reset pin high");
  prog_sel_block_a: assert property ((!card_rst && program_select_input) [*5] |=> !data_oe)
    else $error("data line driven with program select high");
  addr_top_a: assert property (trace_valid |-> trace_data[11:1] <= `ADDR_LAST)
    else $error("traced address past wrap point");
  trace_hold_a: assert property (stalled |=> trace_valid && $stable(trace_data))
    else $error("trace word lost during stall");
  por_clear_a: assert property ($rose(presetn) |-> !data_oe && !trace_valid)
    else $error("outputs not cleared by power-on reset");
endmodule // bit_access_checker
bind serial_bit_memory_access bit_access_checker #(.ADDR_W(ADDR_W), .MEM_BITS(MEM_BITS)) bit_access_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .card_rst(card_rst), .program_select_input(program_select_input), .data_out(data_out),
  .data_oe(data_oe), .trace_valid(trace_valid), .trace_ready(trace_ready), .trace_data(trace_data));
`default_nettype wire

// file: dv/card_host.sv
`timescale 1ns/1ps
`default_nettype none
// reader-side pin driver with the pulled-up data line
module card_host (
  // clock
  input  wire logic pclk,
  // card pins
  output logic      card_clk,
  output logic      card_rst,
  output logic      program_select_input,
  // data line
  input  wire logic data_out,
  input  wire logic data_oe,
  output wire logic data_in
);
  // released line floats up through the pull-up
  assign data_in = data_oe ? data_out : 1'b1;
  // idle pins: clock low, reset pulled up, read select
  initial begin
    card_clk = 1'b0;
    card_rst = 1'b1;
    program_select_input = 1'b0;
  end
  // margin over the two-flop sync plus the output flop
  task automatic settle;
    repeat (6) @(posedge pclk);
  endtask
  // pin level changes just after an edge
  task automatic set_rst(input logic v);
    @(posedge pclk) card_rst <= v;
    settle();
  endtask
  task automatic set_prog_sel(input logic v);
    @(posedge pclk) program_select_input <= v;
    settle();
  endtask
  // address reset with the clock held low
  task automatic addr_reset;
    set_rst(1'b1);
    set_rst(1'b0);
  endtask
  // n clock pulses, reset as left by the caller
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge pclk) card_clk <= 1'b1;
      settle();
      @(posedge pclk) card_clk <= 1'b0;
      settle();
    end
  endtask
endmodule // card_host
`default_nettype wire

// file: dv/serial_bit_memory_access_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bit_access_defines.vh"
module serial_bit_memory_access_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, trace_ready, errv;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdv;
  wire  [31:0] prdata;
  wire  [11:0] trace_data;
  wire         pready, pslverr, card_clk, card_rst, prog_sel, data_in, data_out, data_oe, trace_valid;
  int          failures, checks_done;
  serial_bit_memory_access serial_bit_memory_access_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .card_clk(card_clk),
    .card_rst(card_rst), .program_select_input(prog_sel), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .trace_valid(trace_valid), .trace_ready(trace_ready), .trace_data(trace_data));
  card_host card_host_i (
    .pclk(pclk), .card_clk(card_clk), .card_rst(card_rst), .program_select_input(prog_sel),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  // 125 mhz
  always #4 pclk = ~pclk;
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; bounded wait on pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      $display("[ERR] %0t apb timeout", $time);
      print_verdict();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdv, exp);
  endtask
  // main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 12'h000; pwdata = 32'h0; trace_ready = 1; failures = 0; checks_done = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`OFS_CTRL, 32'h00000001);
    rd_chk(`OFS_ADDR, 32'h0);
    rd_chk(`OFS_FLAGS, 32'h0);
    rd_chk(`OFS_RD_LIMIT, 32'h0000063f);
    check(32'(data_oe), 32'h0);
    $display("power-on test done");
    // zero bits at 0 and 17, flags all set
    wr(`OFS_MEM_ADDR, 32'h0);
    wr(`OFS_MEM_DATA, 32'h0);
    wr(`OFS_MEM_ADDR, 32'h11);
    wr(`OFS_MEM_DATA, 32'h0);
    wr(`OFS_FLAGS, 32'h3ff);
    rd_chk(`OFS_FLAGS, 32'h3ff);
    card_host_i.addr_reset();
    rd_chk(`OFS_ADDR, 32'h0);
    rd_chk(`OFS_FLAGS, 32'h3f8);
    check(32'(data_oe), 32'h1);
    check(32'(data_in), 32'h0);
    rd_chk(`OFS_STATUS, 32'h0);
    card_host_i.set_prog_sel(1'b1);
    check(32'(data_oe), 32'h0);
    card_host_i.set_prog_sel(1'b0);
    $display("address reset test done");
    card_host_i.pulse(16);
    rd_chk(`OFS_ADDR, 32'h10);
    check(32'(data_oe), 32'h0);
    check(32'(data_in), 32'h1);
    // 16 steps counted, issuer zone, line released high
    rd_chk(`OFS_STATUS, 32'h0000010a);
    // reset high blocks steps; its fall clears
    card_host_i.set_rst(1'b1);
    card_host_i.pulse(2);
    rd_chk(`OFS_ADDR, 32'h10);
    card_host_i.set_rst(1'b0);
    rd_chk(`OFS_ADDR, 32'h0);
    $display("stepping test done");
    // reads above the limit are refused
    wr(`OFS_RD_LIMIT, 32'h10);
    card_host_i.pulse(17);
    check(32'(data_oe), 32'h0);
    card_host_i.pulse(1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check(rdv & 32'h1, 32'h1);
    wr(`OFS_STATUS, 32'h1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check(rdv & 32'h1, 32'h0);
    $display("refusal test done");
    // full buffer stalls the counter, nothing lost
    trace_ready <= 1'b0;
    card_host_i.pulse(3);
    rd_chk(`OFS_ADDR, 32'h14);
    // oldest held word is the step to 19, bit one
    check(32'(trace_valid), 32'h1);
    check(32'(trace_data), 32'h027);
    trace_ready <= 1'b1;
    card_host_i.pulse(1);
    rd_chk(`OFS_ADDR, 32'h15);
    check(32'(trace_valid), 32'h0);
    $display("stall test done");
    // wrap after the last address
    wr(`OFS_FLAGS, 32'h3ff);
    card_host_i.pulse(1578);
    rd_chk(`OFS_ADDR, 32'h63f);
    rd_chk(`OFS_FLAGS, 32'h3ff);
    card_host_i.pulse(1);
    rd_chk(`OFS_ADDR, 32'h0);
    rd_chk(`OFS_FLAGS, 32'h3f8);
    $display("wrap test done");
    apb(1'b0, 12'h040, 32'h0);
    check(32'(errv), 32'h1);
    wr(`OFS_ADDR, 32'h5);
    rd_chk(`OFS_ADDR, 32'h0);
    $display("bus refusal test done");
    // power-on reset in mid-run clears retained flags and the address
    wr(`OFS_FLAGS, 32'h3ff);
    card_host_i.pulse(3);
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`OFS_FLAGS, 32'h0);
    rd_chk(`OFS_ADDR, 32'h0);
    check(32'(data_oe), 32'h0);
    $display("second reset test done");
    print_verdict();
  end
endmodule // serial_bit_memory_access_tb_top
`default_nettype wire
